// file: common/lss_pkg.sv
// Shared constants and types for the layer setting commissioning handler
package lss_pkg;
  // Frame identifiers
  localparam logic [10:0] ID_SLAVE_RX = 11'h7e5; // Requests arrive here
  localparam logic [10:0] ID_MASTER_TX = 11'h7e4; // Responses leave here
  localparam logic [3:0] FRAME_LEN = 4'h8; // Every frame carries eight bytes
  // Command specifiers
  localparam logic [7:0] CS_SWITCH_GLOBAL = 8'h04;
  localparam logic [7:0] CS_SEL_VENDOR = 8'h40;
  localparam logic [7:0] CS_SEL_PRODUCT = 8'h41;
  localparam logic [7:0] CS_SEL_REVISION = 8'h42;
  localparam logic [7:0] CS_SEL_SERIAL = 8'h43;
  localparam logic [7:0] CS_SEL_RESPONSE = 8'h44;
  localparam logic [7:0] CS_SET_NODE = 8'h11;
  localparam logic [7:0] CS_SET_RATE = 8'h13;
  localparam logic [7:0] CS_STORE = 8'h17;
  // Switch mode argument values
  localparam logic [7:0] SW_ARG_OPER = 8'h00;
  localparam logic [7:0] SW_ARG_CONF = 8'h01;
  // Answer codes
  localparam logic [7:0] ERR_OK = 8'h00;
  localparam logic [7:0] ERR_RANGE = 8'h01;
  // Node identifier and bit-rate limits and defaults
  localparam logic [6:0] NODE_DEFAULT = 7'h41;
  localparam logic [6:0] NODE_MIN = 7'h01;
  localparam logic [6:0] NODE_MAX = 7'h7f;
  localparam logic [3:0] RATE_DEFAULT = 4'h0; // Index 0 is 1000 kbps
  localparam logic [3:0] RATE_MAX = 4'h8; // Index 8 is 10 kbps
  localparam logic [7:0] RATE_TABLE_SEL = 8'h00; // Only the standard table
  // Bit rate in kbps for each table index
  localparam logic [15:0] RATE_KBPS [0:8] = '{16'h03e8, 16'h0320, 16'h01f4,
    16'h00fa, 16'h007d, 16'h0064, 16'h0032, 16'h0014, 16'h000a};

  // One CAN data frame, byte 0 first
  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [7:0][7:0] data; // data[0] is the first byte
  } can_frame_t;

  // A configuration as held in non-volatile storage
  typedef struct packed {
    logic [6:0] node_id;
    logic [3:0] rate_idx;
  } nv_cfg_t;

  // Operating or configuration mode
  typedef enum logic [1:0] {
    MODE_OPER = 2'b00,
    MODE_CONF = 2'b01
  } lss_mode_t;
endpackage : lss_pkg

// file: logic/lss_rx_filter.sv
// Request filter: passes only eight-byte frames on the slave identifier
`timescale 1ns/1ns
module lss_rx_filter
  import lss_pkg::*;
(
  input wire logic rx_valid_i, // Frame present this cycle
  input can_frame_t rx_frame_i, // Received frame
  output logic req_valid_o, // Accepted request
  output logic [7:0] req_cs_o, // Command specifier
  output logic [31:0] req_word_o // Bytes 1 to 4, byte 1 least significant
);
  // Identifier and length check
  wire id_hit = (rx_frame_i.id == ID_SLAVE_RX);
  wire len_hit = (rx_frame_i.dlc == FRAME_LEN);

  assign req_valid_o = rx_valid_i & id_hit & len_hit;
  assign req_cs_o = rx_frame_i.data[0];
  assign req_word_o = {rx_frame_i.data[4], rx_frame_i.data[3],
                       rx_frame_i.data[2], rx_frame_i.data[1]};
endmodule : lss_rx_filter

// file: logic/lss_sig_match.sv
// Four-part selective signature matcher
`timescale 1ns/1ns
module lss_sig_match
  import lss_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic en_i, // Matching allowed (operational mode)
  input wire logic req_valid_i, // Accepted request
  input wire logic [7:0] req_cs_i, // Command specifier
  input wire logic [31:0] req_word_i, // Signature part value
  input wire logic [31:0] vendor_i, // Own vendor identifier
  input wire logic [31:0] product_i, // Own product code
  input wire logic [31:0] revision_i, // Own revision number
  input wire logic [31:0] serial_i, // Own serial number
  output logic hit_o // Whole signature matched, one-cycle pulse
);
  logic [2:0] parts_q; // Parts matched so far, in order
  logic [2:0] parts_d;

  // Decode of each part against its own value
  wire is_v = req_valid_i & en_i & (req_cs_i == CS_SEL_VENDOR);
  wire is_p = req_valid_i & en_i & (req_cs_i == CS_SEL_PRODUCT);
  wire is_r = req_valid_i & en_i & (req_cs_i == CS_SEL_REVISION);
  wire is_s = req_valid_i & en_i & (req_cs_i == CS_SEL_SERIAL);
  wire ok_v = (req_word_i == vendor_i);
  wire ok_p = (req_word_i == product_i) & parts_q[0];
  wire ok_r = (req_word_i == revision_i) & parts_q[1];
  wire ok_s = (req_word_i == serial_i) & parts_q[2];

  // Whole match only after all earlier parts matched
  assign hit_o = is_s & ok_s;

  // Next match progress; a wrong part restarts the sequence
  always_comb
  begin
    parts_d = parts_q;
    if (!en_i)
    begin
      parts_d = 3'h0;
    end
    else if (is_v)
    begin
      parts_d = {2'h0, ok_v};
    end
    else if (is_p)
    begin
      parts_d = {1'h0, ok_p, ok_p};
    end
    else if (is_r)
    begin
      parts_d = ok_r ? 3'h7 : 3'h0;
    end
    else if (is_s)
    begin
      parts_d = 3'h0;
    end
  end

  // Progress register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      parts_q <= 3'h0;
    else
      parts_q <= parts_d;
  end
endmodule : lss_sig_match

// file: logic/lss_commission.sv
// Layer setting commissioning handler: mode control, configuration, responses
`timescale 1ns/1ns
// What this block does
// - Take requests only on identifier 07E5
// - Send every response on identifier 07E4
// - Global switch puts node into configuration
// - Selective switch needs all four signature parts
// - Configuration changes only in configuration mode
// - No answer to global switch command
// - Bit rate is table index 0 to 8
// - Store command 17 saves identifier and rate
// - New node identifier active on operational
// - New bit rate applied only after power cycle
// - Frames are eight bytes, specifier first
// - Factory default node identifier is 41
module lss_commission
  import lss_pkg::*;
#(
  parameter logic [31:0] VENDOR_ID = 32'h00000001, // Arbitrary value
  parameter logic [31:0] PRODUCT_CODE = 32'h00000002, // Arbitrary value
  parameter logic [31:0] REVISION_NUM = 32'h00000003 // Arbitrary value
)
(
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_i, // Synchronous reset, active high (power cycle)
  input wire logic rx_valid_i, // Received frame present
  input can_frame_t rx_frame_i, // Received frame
  output logic rx_ready_o, // Frame taken this cycle
  output logic tx_valid_o, // Response frame waiting
  output can_frame_t tx_frame_o, // Response frame
  input wire logic tx_ready_i, // Controller takes the response
  input wire logic [31:0] serial_i, // Own serial number
  input wire logic nv_valid_i, // Stored configuration is present
  input nv_cfg_t nv_cfg_i, // Stored configuration read at start
  output logic nv_wr_o, // Write stored configuration, one pulse
  output nv_cfg_t nv_cfg_o, // Configuration to write
  output logic conf_mode_o, // High in configuration mode
  output logic [6:0] node_id_o, // Node identifier in use
  output logic [3:0] rate_idx_o, // Bit-rate index in use
  output logic [15:0] rate_kbps_o // Bit rate in use, kbps
);
  // Request fields from the filter
  logic req_valid; // Request on the slave identifier
  logic [7:0] req_cs; // Its command specifier
  logic [31:0] req_word; // Its bytes 1 to 4
  logic sel_hit; // Selective signature matched

  // State
  lss_mode_t mode_q; // Operational or configuration mode
  lss_mode_t mode_d;
  logic boot_q; // First cycle after reset, load stored values
  logic [6:0] node_q; // Node identifier in use
  logic [6:0] node_d;
  logic [3:0] rate_q; // Bit rate in use, fixed until power cycle
  logic [6:0] pend_node_q; // Configured node identifier
  logic [6:0] pend_node_d;
  logic [3:0] pend_rate_q; // Configured bit-rate index
  logic [3:0] pend_rate_d;
  logic nv_wr_q; // Store strobe
  nv_cfg_t nv_cfg_q; // Store data
  logic tx_valid_q; // Response pending
  logic tx_valid_d;
  can_frame_t tx_frame_q; // Response frame
  can_frame_t tx_frame_d;

  // Build an eight-byte response on the master identifier
  function automatic can_frame_t make_resp(input logic [7:0] cs,
                                           input logic [7:0] b1,
                                           input logic [7:0] b2);
    can_frame_t f;
    f = '0;
    f.id = ID_MASTER_TX;
    f.dlc = FRAME_LEN;
    f.data[0] = cs;
    f.data[1] = b1;
    f.data[2] = b2;
    return f;
  endfunction : make_resp

  // Identifier and length filter
  lss_rx_filter u_filter (
    .rx_valid_i(rx_valid_i & rx_ready_o),
    .rx_frame_i(rx_frame_i),
    .req_valid_o(req_valid),
    .req_cs_o(req_cs),
    .req_word_o(req_word)
  );

  // Selective signature matcher, active only in operational mode
  lss_sig_match u_sig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(mode_q == MODE_OPER),
    .req_valid_i(req_valid),
    .req_cs_i(req_cs),
    .req_word_i(req_word),
    .vendor_i(VENDOR_ID),
    .product_i(PRODUCT_CODE),
    .revision_i(REVISION_NUM),
    .serial_i(serial_i),
    .hit_o(sel_hit)
  );

  // Frames are taken while no response waits and not during the boot load
  assign rx_ready_o = ~tx_valid_q & ~boot_q;

  // Command decode
  wire in_conf = (mode_q == MODE_CONF);
  // Switch argument sits in byte 1 of the request
  wire cmd_global = req_valid & (req_cs == CS_SWITCH_GLOBAL);
  wire glob_conf = cmd_global & (req_word[7:0] == SW_ARG_CONF);
  wire glob_oper = cmd_global & (req_word[7:0] == SW_ARG_OPER);
  // Set and store only count in configuration mode
  wire cmd_node = req_valid & in_conf & (req_cs == CS_SET_NODE);
  wire cmd_rate = req_valid & in_conf & (req_cs == CS_SET_RATE);
  wire cmd_store = req_valid & in_conf & (req_cs == CS_STORE);
  // Range checks on the new values
  wire [6:0] new_node = req_word[6:0];
  wire node_ok = (req_word[7:0] <= {1'h0, NODE_MAX})
                 & (new_node >= NODE_MIN);
  wire [7:0] new_sel = req_word[7:0];
  wire [7:0] new_rate = req_word[15:8];
  wire rate_ok = (new_sel == RATE_TABLE_SEL)
                 & (new_rate <= {4'h0, RATE_MAX});

  // Mode transitions
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      MODE_OPER:
      begin
        // Enter configuration by global switch or signature match
        if (glob_conf || sel_hit)
          mode_d = MODE_CONF;
      end
      MODE_CONF:
      begin
        // Leave configuration only by the global switch back
        if (glob_oper)
          mode_d = MODE_OPER;
      end
      default:
      begin
        mode_d = MODE_OPER;
      end
    endcase
  end

  // Configuration values and the identifier in use
  always_comb
  begin
    pend_node_d = pend_node_q;
    pend_rate_d = pend_rate_q;
    node_d = node_q;
    if (cmd_node && node_ok)
    begin
      pend_node_d = new_node;
    end
    if (cmd_rate && rate_ok)
    begin
      pend_rate_d = new_rate[3:0];
    end
    if (in_conf && glob_oper)
    begin
      // The new identifier takes effect at once
      node_d = pend_node_q;
    end
  end

  // Response builder; global switch gets none either way
  always_comb
  begin
    tx_valid_d = tx_valid_q & ~tx_ready_i;
    tx_frame_d = tx_frame_q;
    if (sel_hit)
    begin
      // Acknowledge the completed signature
      tx_valid_d = 1'h1;
      tx_frame_d = make_resp(CS_SEL_RESPONSE, 8'h00, 8'h00);
    end
    else if (cmd_node)
    begin
      // Answer with success or out of range
      tx_valid_d = 1'h1;
      tx_frame_d = make_resp(CS_SET_NODE, node_ok ? ERR_OK : ERR_RANGE, 8'h00);
    end
    else if (cmd_rate)
    begin
      // Answer with success or unsupported index
      tx_valid_d = 1'h1;
      tx_frame_d = make_resp(CS_SET_RATE, rate_ok ? ERR_OK : ERR_RANGE, 8'h00);
    end
    else if (cmd_store)
    begin
      // Storage write is accepted without error
      tx_valid_d = 1'h1;
      tx_frame_d = make_resp(CS_STORE, ERR_OK, 8'h00);
    end
  end

  // Mode and boot flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= MODE_OPER;
      boot_q <= 1'h1;
    end
    else
    begin
      mode_q <= mode_d;
      boot_q <= 1'h0;
    end
  end

  // Identifier and rate in use; loaded once after reset release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      node_q <= NODE_DEFAULT;
      rate_q <= RATE_DEFAULT;
    end
    else if (boot_q)
    begin
      // Stored values if present, otherwise factory defaults
      node_q <= nv_valid_i ? nv_cfg_i.node_id : NODE_DEFAULT;
      rate_q <= nv_valid_i ? nv_cfg_i.rate_idx : RATE_DEFAULT;
    end
    else
    begin
      node_q <= node_d;
    end
  end

  // Configured values, seeded from the values in use at boot
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_node_q <= NODE_DEFAULT;
      pend_rate_q <= RATE_DEFAULT;
    end
    else if (boot_q)
    begin
      pend_node_q <= nv_valid_i ? nv_cfg_i.node_id : NODE_DEFAULT;
      pend_rate_q <= nv_valid_i ? nv_cfg_i.rate_idx : RATE_DEFAULT;
    end
    else
    begin
      pend_node_q <= pend_node_d;
      pend_rate_q <= pend_rate_d;
    end
  end

  // Storage write strobe with the configured values
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nv_wr_q <= 1'h0;
      nv_cfg_q <= '0;
    end
    else
    begin
      nv_wr_q <= cmd_store;
      if (cmd_store)
        nv_cfg_q <= '{node_id: pend_node_q, rate_idx: pend_rate_q};
    end
  end

  // Response holding register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_valid_q <= 1'h0;
      tx_frame_q <= '0;
    end
    else
    begin
      tx_valid_q <= tx_valid_d;
      tx_frame_q <= tx_frame_d;
    end
  end

  // Outputs
  assign tx_valid_o = tx_valid_q;
  assign tx_frame_o = tx_frame_q;
  assign nv_wr_o = nv_wr_q;
  assign nv_cfg_o = nv_cfg_q;
  assign conf_mode_o = in_conf;
  assign node_id_o = node_q;
  assign rate_idx_o = rate_q;
  assign rate_kbps_o = RATE_KBPS[rate_q];
endmodule : lss_commission

// file: sim/lss_commission_checker.sv
// Port-level property checker for the commissioning handler
`timescale 1ns/1ns
module lss_commission_checker
  import lss_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input can_frame_t rx_frame_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input can_frame_t tx_frame_o,
  input wire logic tx_ready_i,
  input wire logic nv_wr_o,
  input wire logic conf_mode_o,
  input wire logic [6:0] node_id_o,
  input wire logic [3:0] rate_idx_o,
  input wire logic [15:0] rate_kbps_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Full frame taken, and the same on the slave identifier
  wire take = rx_valid_i && rx_ready_o && rx_frame_i.dlc == FRAME_LEN;
  wire ok = take && rx_frame_i.id == ID_SLAVE_RX;
  wire [7:0] cs = rx_frame_i.data[0];
  wire [7:0] arg = rx_frame_i.data[1];
  wire setcmd = cs == CS_SET_NODE || cs == CS_SET_RATE || cs == CS_STORE;
  property p_drop_id;
    take && rx_frame_i.id != ID_SLAVE_RX |=> !tx_valid_o && $stable(conf_mode_o);
  endproperty
  a_drop_id: assert property (p_drop_id) else $error("foreign frame acted on");
  property p_resp_frame;
    tx_valid_o |-> tx_frame_o.id == ID_MASTER_TX && tx_frame_o.dlc == FRAME_LEN;
  endproperty
  a_resp_frame: assert property (p_resp_frame) else $error("bad answer header");
  property p_tx_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_frame_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("answer dropped early");
  property p_glob_conf;
    ok && cs == CS_SWITCH_GLOBAL && arg == SW_ARG_CONF |=> conf_mode_o && !tx_valid_o;
  endproperty
  a_glob_conf: assert property (p_glob_conf) else $error("global entry wrong");
  property p_glob_oper;
    ok && cs == CS_SWITCH_GLOBAL && arg == SW_ARG_OPER |=> !conf_mode_o && !tx_valid_o;
  endproperty
  a_glob_oper: assert property (p_glob_oper) else $error("global exit wrong");
  property p_oper_quiet;
    ok && !conf_mode_o && setcmd |=> !tx_valid_o && !nv_wr_o;
  endproperty
  a_oper_quiet: assert property (p_oper_quiet) else $error("set acted on");
  property p_store;
    ok && conf_mode_o && cs == CS_STORE |=> nv_wr_o && tx_frame_o.data[0] == CS_STORE;
  endproperty
  a_store: assert property (p_store) else $error("store not written");
  property p_node_conf;
    conf_mode_o && $past(conf_mode_o) |-> $stable(node_id_o);
  endproperty
  a_node_conf: assert property (p_node_conf) else $error("node moved early");
  property p_rate_boot;
    !$past(rst_i) && !$past(rst_i, 2) |-> $stable(rate_idx_o);
  endproperty
  a_rate_boot: assert property (p_rate_boot) else $error("rate moved live");
  property p_kbps;
    rate_idx_o <= RATE_MAX |-> rate_kbps_o == RATE_KBPS[rate_idx_o];
  endproperty
  a_kbps: assert property (p_kbps) else $error("rate table wrong");
  // Main scenarios reached
  c_glob: cover property (ok && cs == CS_SWITCH_GLOBAL ##1 conf_mode_o);
  c_store: cover property (nv_wr_o);
  c_sel: cover property (tx_valid_o && tx_frame_o.data[0] == CS_SEL_RESPONSE);
endmodule : lss_commission_checker

bind lss_commission lss_commission_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i), .rx_ready_o(rx_ready_o),
  .tx_valid_o(tx_valid_o), .tx_frame_o(tx_frame_o), .tx_ready_i(tx_ready_i),
  .nv_wr_o(nv_wr_o), .conf_mode_o(conf_mode_o), .node_id_o(node_id_o),
  .rate_idx_o(rate_idx_o), .rate_kbps_o(rate_kbps_o));

// file: sim/lss_master_model.sv
// Commissioning master model: offers requests, takes answers
`timescale 1ns/1ns
module lss_master_model
  import lss_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i, // Hold answers off from the next cycle
  input wire logic rx_ready_i, // Device takes the request
  output logic rx_valid_o,
  output can_frame_t rx_frame_o,
  input wire logic tx_valid_i,
  input can_frame_t tx_frame_i,
  output logic tx_ready_o,
  output can_frame_t last_o, // Last answer taken
  output logic [15:0] n_resp_o // Answers taken since reset
);
  initial
  begin
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
    tx_ready_o = 1'b0;
  end
  // Offer one request frame until taken, then scramble the lines
  task automatic send(input can_frame_t f);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_frame_o <= f;
    do
      @(posedge clk_i);
    while (rx_ready_i !== 1'b1);
    rx_valid_o <= 1'b0;
    rx_frame_o <= ~f;
  endtask : send
  // Take answers unless stalled, keep the last one
  always @(posedge clk_i)
  begin
    tx_ready_o <= ~stall_i;
    if (rst_i)
      n_resp_o <= 16'h0;
    else if (tx_valid_i && tx_ready_o)
    begin
      n_resp_o <= n_resp_o + 16'h1;
      last_o <= tx_frame_i;
    end
  end
endmodule : lss_master_model

// file: sim/lss_commission_tb_top.sv
// Self-checking bench for the commissioning handler
`timescale 1ns/1ns
module lss_commission_tb_top
  import lss_pkg::*;
;
  localparam logic [31:0] VEN = 32'h00001234; // Arbitrary value
  localparam logic [31:0] PRD = 32'h00000056; // Arbitrary value
  localparam logic [31:0] REV = 32'h00000789; // Arbitrary value
  localparam logic [15:0] KBPS [9] = '{16'h03e8, 16'h0320, 16'h01f4, 16'h00fa,
    16'h007d, 16'h0064, 16'h0032, 16'h0014, 16'h000a};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rx_valid, rx_ready, tx_valid, tx_ready, nv_valid, nv_wr, conf_mode, stall;
  can_frame_t rx_frame, tx_frame, last, f;
  nv_cfg_t nv_cfg_in, nv_cfg_out, nv_seen;
  logic [31:0] serial, seed;
  logic [6:0] node_id, new_node;
  logic [3:0] rate_idx, new_rate;
  logic [15:0] rate_kbps, n_resp;
  int n_mismatch = 0;
  int check_count = 0;
  initial
    forever #5 clk_i = ~clk_i;
  lss_commission #(.VENDOR_ID(VEN), .PRODUCT_CODE(PRD), .REVISION_NUM(REV)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid), .rx_frame_i(rx_frame),
    .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_frame_o(tx_frame),
    .tx_ready_i(tx_ready), .serial_i(serial), .nv_valid_i(nv_valid), .nv_cfg_i(nv_cfg_in),
    .nv_wr_o(nv_wr), .nv_cfg_o(nv_cfg_out), .conf_mode_o(conf_mode), .node_id_o(node_id),
    .rate_idx_o(rate_idx), .rate_kbps_o(rate_kbps));
  lss_master_model m_u (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .rx_ready_i(rx_ready),
    .rx_valid_o(rx_valid), .rx_frame_o(rx_frame), .tx_valid_i(tx_valid),
    .tx_frame_i(tx_frame), .tx_ready_o(tx_ready), .last_o(last), .n_resp_o(n_resp));
  // Next value of the random sequence
  function automatic logic [31:0] nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : nxt
  // Request frame on the slave identifier, word in bytes 1 to 4
  function automatic can_frame_t mk(input logic [7:0] cs, input logic [31:0] w);
    mk = '0;
    mk.id = ID_SLAVE_RX;
    mk.dlc = FRAME_LEN;
    mk.data[0] = cs;
    {mk.data[4], mk.data[3], mk.data[2], mk.data[1]} = w;
  endfunction : mk
  // Random answer stalls; capture of the storage write
  always @(posedge clk_i)
  begin
    stall <= (nxt() & 32'h3) == 32'h0;
    if (nv_wr)
      nv_seen <= nv_cfg_out;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // Send one request, wait out its answer, compare count and answer
  task automatic cmd(input can_frame_t r, input logic [15:0] nr, input logic [7:0] ecs,
    input logic [7:0] err);
    logic [15:0] n0;
    int i;
    n0 = n_resp;
    i = 0;
    m_u.send(r);
    repeat (3) @(posedge clk_i);
    while (tx_valid === 1'b1 && i < 60)
    begin
      @(posedge clk_i);
      i++;
    end
    repeat (2) @(posedge clk_i);
    chk(32'(n_resp - n0), 32'(nr));
    if (nr == 16'h1)
    begin
      chk(32'(last.id), 32'(ID_MASTER_TX));
      chk(32'(last.data[0]), 32'(ecs));
      chk(32'(last.data[1]), 32'(err));
    end
  endtask : cmd
  // Four-part signature, serial part last
  task automatic sel(input logic [31:0] s, input logic [15:0] nr);
    cmd(mk(CS_SEL_VENDOR, VEN), 16'h0, 8'h00, 8'h00);
    cmd(mk(CS_SEL_PRODUCT, PRD), 16'h0, 8'h00, 8'h00);
    cmd(mk(CS_SEL_REVISION, REV), 16'h0, 8'h00, 8'h00);
    cmd(mk(CS_SEL_SERIAL, s), nr, CS_SEL_RESPONSE, ERR_OK);
  endtask : sel
  // Power cycle with a given stored configuration
  task automatic boot(input logic v, input nv_cfg_t c);
    rst_i <= 1'b1;
    nv_valid <= v;
    nv_cfg_in <= c;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Let the boot load settle before anything is compared
    repeat (2) @(posedge clk_i);
  endtask : boot
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    seed = 32'h0c47f22e;
    serial = nxt();
    boot(1'b0, '0);
    chk(32'(node_id), 32'(NODE_DEFAULT));
    chk(32'(rate_kbps), 32'h03e8);
    cmd(mk(CS_SET_NODE, 32'h22), 16'h0, 8'h00, 8'h00);
    cmd(mk(CS_SET_RATE, 32'h0300), 16'h0, 8'h00, 8'h00);
    cmd(mk(CS_STORE, 32'h0), 16'h0, 8'h00, 8'h00);
    f = mk(CS_SWITCH_GLOBAL, 32'h1);
    f.id = ID_MASTER_TX;
    cmd(f, 16'h0, 8'h00, 8'h00);
    chk(32'(conf_mode), 32'h0);
    f.id = ID_SLAVE_RX;
    f.dlc = 4'h7;
    cmd(f, 16'h0, 8'h00, 8'h00);
    chk(32'(conf_mode), 32'h0);
    $display("test operational done");
    sel(serial ^ 32'h1, 16'h0);
    chk(32'(conf_mode), 32'h0);
    sel(serial, 16'h1);
    chk(32'(conf_mode), 32'h1);
    $display("test selective done");
    cmd(mk(CS_SET_NODE, 32'h0), 16'h1, CS_SET_NODE, ERR_RANGE);
    new_node = 7'(nxt()) | 7'h01;
    cmd(mk(CS_SET_NODE, {25'h0, new_node}), 16'h1, CS_SET_NODE, ERR_OK);
    for (int k = 0; k < 10; k++)
      cmd(mk(CS_SET_RATE, 32'(k) << 8), 16'h1, CS_SET_RATE, k > 8 ? ERR_RANGE : ERR_OK);
    cmd(mk(CS_SET_RATE, 32'h0101), 16'h1, CS_SET_RATE, ERR_RANGE);
    new_rate = 4'(nxt() % 32'h9);
    cmd(mk(CS_SET_RATE, {20'h0, new_rate, 8'h00}), 16'h1, CS_SET_RATE, ERR_OK);
    chk(32'(node_id), 32'(NODE_DEFAULT));
    cmd(mk(CS_STORE, 32'h0), 16'h1, CS_STORE, ERR_OK);
    chk(32'(nv_seen), 32'({new_node, new_rate}));
    cmd(mk(CS_SWITCH_GLOBAL, 32'(SW_ARG_OPER)), 16'h0, 8'h00, 8'h00);
    chk(32'(conf_mode), 32'h0);
    chk(32'(node_id), 32'(new_node));
    chk(32'(rate_idx), 32'(RATE_DEFAULT));
    $display("test configure done");
    boot(1'b1, nv_seen);
    chk(32'(rate_idx), 32'(new_rate));
    chk(32'(rate_kbps), 32'(KBPS[new_rate]));
    cmd(mk(CS_SWITCH_GLOBAL, 32'(SW_ARG_CONF)), 16'h0, 8'h00, 8'h00);
    chk(32'(conf_mode), 32'h1);
    $display("test power cycle done");
    stop_test();
  end
endmodule : lss_commission_tb_top
